/* File: src/acs_consts.vh */
// Purpose: Constants for the converter conversion sequencer: register offsets, fields, resets, timing.
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per register.
// Notes: Included by acs_top.v only.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// ****************************************
// Register word offsets
// ****************************************
`define ACS_OFF_CH_CTRL 4'h0
`define ACS_OFF_TRIG_CMP 4'h1
`define ACS_OFF_RES_HI 4'h2
`define ACS_OFF_RES_LO 4'h3
`define ACS_OFF_CMP_HI 4'h4
`define ACS_OFF_CMP_LO 4'h5
`define ACS_OFF_CFG 4'h6
// ****************************************
// Field positions
// ****************************************
`define ACS_CH_DONE 7
`define ACS_CH_IEN 6
`define ACS_CH_CONT 5
`define ACS_TC_ACTIVE 7
`define ACS_TC_HWT 6
`define ACS_TC_CMPEN 5
`define ACS_TC_CMPGT 4
`define ACS_CFG_LSMP 4
// ****************************************
// Reset values
// ****************************************
`define ACS_RST_CH 8'h1f
`define ACS_RST_TC 8'h00
`define ACS_RST_CFG 8'h00
`define ACS_RST_CMP 8'h00
`define ACS_RST_RES 8'h00
`define ACS_CH_OFF 5'h1f
// ****************************************
// Timing, in conversion clock cycles unless named otherwise
// ****************************************
`define ACS_SAMPLE_SHORT 8'd3
`define ACS_SAMPLE_LONG 8'd23
`define ACS_SAR_8 8'd14
`define ACS_SAR_10 8'd17
`define ACS_FIRST_BUS 8'd5
`define ACS_ASYNC_START_NS 5000
`define ACS_MCLK_NS 20
`define ACS_ASYNC_START_CYC ((`ACS_ASYNC_START_NS) / (`ACS_MCLK_NS))
`endif

/* File: src/acs_top.v */
// Purpose: Conversion sequencer of a successive-approximation converter, with Avalon-MM registers.
// Assumes: Analog core delivers sar_data; converter clock is an mclk-domain enable from the divider here.
// Notes: Reads of result_hi in 10-bit mode arm the blocking latch; result_lo read releases it.
`timescale 1ns/1ps
`include "acs_consts.vh"
module acs_top #(
  parameter ASYNC_START_CYC = `ACS_ASYNC_START_CYC
)
(
  input wire mclk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire hw_trigger_in,
  input wire stop_req,
  input wire [9:0] sar_data,
  output reg irq,
  output reg async_clk_en,
  output reg sample_en,
  output reg converter_busy
);

  // ****************************************
  // Registers and state
  // ****************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_SAMPLE = 3'd2;
  localparam ST_SAR = 3'd3;
  localparam ST_XFER = 3'd4;

  reg [7:0] ch_ctrl_r;
  reg [7:0] tc_r;
  reg [7:0] cfg_r;
  reg [7:0] cmp_hi_r;
  reg [7:0] cmp_lo_r;
  reg [7:0] res_hi_r;
  reg [7:0] res_lo_r;
  reg block_r;
  reg [2:0] state_r;
  reg [15:0] cnt_r;
  reg first_r;
  reg [2:0] div_r;
  reg trig_s1_r;
  reg trig_s2_r;
  reg trig_d_r;
  reg stop_s1_r;
  reg stop_s2_r;
  reg stop_d_r;
  reg acc_r;

  wire [1:0] clk_sel = cfg_r[1:0];
  wire [1:0] clk_div = cfg_r[6:5];
  wire mode10 = (cfg_r[3:2] == 2'b10);
  wire async_sel = (clk_sel == 2'b11);
  wire ch_off = (ch_ctrl_r[4:0] == `ACS_CH_OFF);

  // Returns the prescale terminal count for the divider and bus-halving selects.
  function [2:0] acs_div_max;
    input [1:0] sel;
    input [1:0] dv;
    reg [3:0] n;
    begin
      n = 4'd1 << dv;
      if (sel == 2'b01)
      begin
        n = {n[2:0], 1'b0};
      end
      acs_div_max = n[2:0] - 3'd1;
      if (n == 4'd8)
      begin
        acs_div_max = 3'd7;
      end
    end
  endfunction

  // Converter clock enable; the async and alternate sources are modelled from mclk.
  // Derived from mclk, so the bus is never slower than the converter clock; above divide-by-one the first sample cycle can run short.
  wire ck_tick = (div_r >= acs_div_max(clk_sel, clk_div));

  always @(posedge mclk)
  begin
    if (reset || state_r == ST_IDLE || ck_tick)
      div_r <= 3'd0;
    else
      div_r <= div_r + 3'd1;
  end

  // ****************************************
  // Bus slave decode
  // ****************************************
  // One wait state: the access completes on the second cycle, keeping read data registered.
  wire acc_now = (avs_read || avs_write) && !acc_r;
  wire wr_go = avs_write && acc_r;
  wire rd_go = avs_read && acc_r;
  wire wr_ch = wr_go && avs_address == `ACS_OFF_CH_CTRL;
  wire wr_mode = wr_go && (avs_address == `ACS_OFF_TRIG_CMP || avs_address == `ACS_OFF_CFG ||
                 avs_address == `ACS_OFF_CMP_HI || avs_address == `ACS_OFF_CMP_LO);
  wire rd_hi = rd_go && avs_address == `ACS_OFF_RES_HI;
  wire rd_lo = rd_go && avs_address == `ACS_OFF_RES_LO;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      acc_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      acc_r <= acc_now;
      avs_waitrequest <= !acc_now;
    end
  end

  // ****************************************
  // Trigger and stop synchronisers
  // ****************************************
  always @(posedge mclk)
  begin
    if (reset)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      stop_d_r <= 1'b0;
    end
    else
    begin
      trig_s1_r <= hw_trigger_in;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
      stop_s1_r <= stop_req;
      stop_s2_r <= stop_s1_r;
      stop_d_r <= stop_s2_r;
    end
  end

  wire hw_edge = trig_s2_r && !trig_d_r;
  wire stop_edge = stop_s2_r && !stop_d_r;
  wire busy = (state_r != ST_IDLE);

  // Start sources; a trigger edge during a conversion is simply not a start.
  wire sw_start = wr_ch && !tc_r[`ACS_TC_HWT] &&
                  (avs_writedata[4:0] != `ACS_CH_OFF);
  wire hw_start = tc_r[`ACS_TC_HWT] && hw_edge && !busy && !ch_off;
  wire abort = wr_ch || wr_mode || (stop_edge && !async_sel);

  // ****************************************
  // Compare and result shaping
  // ****************************************
  // Eight-bit mode keeps the upper bits of the approximation, rounded by truncation here.
  wire [9:0] conv = mode10 ? sar_data : {2'b00, sar_data[9:2]};
  wire [9:0] cmpv = mode10 ? {cmp_hi_r[1:0], cmp_lo_r} : {2'b00, cmp_lo_r};
  wire [10:0] diff = {1'b0, conv} + {1'b0, ~cmpv} + 11'd1;
  wire ge = diff[10];
  wire cmp_ok = !tc_r[`ACS_TC_CMPEN] || (tc_r[`ACS_TC_CMPGT] ? ge : !ge);
  wire [9:0] xfer_val = tc_r[`ACS_TC_CMPEN] ? diff[9:0] : conv;
  wire blocked = mode10 && block_r;
  wire cont = ch_ctrl_r[`ACS_CH_CONT];

  // Phase lengths in converter clock cycles; start_len is in mclk cycles.
  wire [7:0] samp_len = cfg_r[`ACS_CFG_LSMP] ? `ACS_SAMPLE_LONG : `ACS_SAMPLE_SHORT;
  wire [7:0] sar_len = mode10 ? `ACS_SAR_10 : `ACS_SAR_8;
  wire [15:0] start_len = async_sel ? ASYNC_START_CYC[15:0] : {8'h00, `ACS_FIRST_BUS};

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // A start always wins over the abort that accompanies it, since an abort-and-restart is one write.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      first_r <= 1'b0;
    end
    else if (sw_start || hw_start)
    begin
      state_r <= ST_START;
      cnt_r <= 16'h0000;
      first_r <= 1'b1;
    end
    else if (abort)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= 16'h0000;
        end
        ST_START:
        begin
          // Bus-clock setup, or oscillator start-up instead for the async source.
          if (cnt_r + 16'd1 >= start_len)
          begin
            state_r <= ST_SAMPLE;
            cnt_r <= 16'h0000;
          end
          else
            cnt_r <= cnt_r + 16'd1;
        end
        ST_SAMPLE:
        begin
          if (ck_tick)
          begin
            if (cnt_r[7:0] + 8'd1 >= samp_len)
            begin
              state_r <= ST_SAR;
              cnt_r <= 16'h0000;
            end
            else
              cnt_r <= cnt_r + 16'd1;
          end
        end
        ST_SAR:
        begin
          if (ck_tick)
          begin
            if (cnt_r[7:0] + 8'd1 >= sar_len)
            begin
              state_r <= ST_XFER;
              cnt_r <= 16'h0000;
            end
            else
              cnt_r <= cnt_r + 16'd1;
          end
        end
        ST_XFER:
        begin
          first_r <= 1'b0;
          cnt_r <= 16'h0000;
          if (tc_r[`ACS_TC_CMPEN] && !cmp_ok && !cont)
            state_r <= ST_IDLE;
          else if (blocked && cmp_ok)
            state_r <= ST_SAMPLE;
          else if (cont || !cmp_ok)
            state_r <= cont ? ST_SAMPLE : ST_IDLE;
          else
            state_r <= ST_IDLE;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  wire do_xfer = (state_r == ST_XFER) && cmp_ok && !blocked && !abort;

  // ****************************************
  // Register file
  // ****************************************
  // Done flag: completion beats a clearing result_lo read in the same cycle; a channel-control write aborts the transfer.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      ch_ctrl_r <= `ACS_RST_CH;
      tc_r <= `ACS_RST_TC;
      cfg_r <= `ACS_RST_CFG;
      cmp_hi_r <= `ACS_RST_CMP;
      cmp_lo_r <= `ACS_RST_CMP;
      res_hi_r <= `ACS_RST_RES;
      res_lo_r <= `ACS_RST_RES;
      block_r <= 1'b0;
    end
    else
    begin
      if (wr_ch)
        ch_ctrl_r[6:0] <= avs_writedata[6:0];
      if (do_xfer)
        ch_ctrl_r[`ACS_CH_DONE] <= 1'b1;
      else if (wr_ch || rd_lo)
        ch_ctrl_r[`ACS_CH_DONE] <= 1'b0;
      if (wr_go && avs_address == `ACS_OFF_TRIG_CMP)
        tc_r[6:4] <= avs_writedata[6:4];
      tc_r[`ACS_TC_ACTIVE] <= busy;
      if (wr_go && avs_address == `ACS_OFF_CFG)
        cfg_r <= avs_writedata[7:0];
      if (wr_go && avs_address == `ACS_OFF_CMP_HI)
        cmp_hi_r <= avs_writedata[7:0];
      if (wr_go && avs_address == `ACS_OFF_CMP_LO)
        cmp_lo_r <= avs_writedata[7:0];
      if (do_xfer)
      begin
        res_hi_r <= {6'h00, xfer_val[9:8]};
        res_lo_r <= xfer_val[7:0];
      end
      if (rd_lo)
        block_r <= 1'b0;
      else if (rd_hi && mode10)
        block_r <= 1'b1;
    end
  end

  // ****************************************
  // Read data, interrupt and analog controls
  // ****************************************
  always @(posedge mclk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h00000000;
      irq <= 1'b0;
      async_clk_en <= 1'b0;
      sample_en <= 1'b0;
      converter_busy <= 1'b0;
    end
    else
    begin
      avs_readdata <= 32'h00000000;
      if (acc_now && avs_read)
      begin
        case (avs_address)
          `ACS_OFF_CH_CTRL: avs_readdata[7:0] <= ch_ctrl_r;
          `ACS_OFF_TRIG_CMP: avs_readdata[7:0] <= {busy, tc_r[6:4], 4'h0};
          `ACS_OFF_RES_HI: avs_readdata[7:0] <= res_hi_r;
          `ACS_OFF_RES_LO: avs_readdata[7:0] <= res_lo_r;
          `ACS_OFF_CMP_HI: avs_readdata[7:0] <= cmp_hi_r;
          `ACS_OFF_CMP_LO: avs_readdata[7:0] <= cmp_lo_r;
          `ACS_OFF_CFG: avs_readdata[7:0] <= cfg_r;
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      irq <= ch_ctrl_r[`ACS_CH_DONE] && ch_ctrl_r[`ACS_CH_IEN];
      async_clk_en <= busy && async_sel;
      sample_en <= (state_r == ST_SAMPLE);
      converter_busy <= busy && !ch_off;
    end
  end

endmodule

/* File: sim/acs_analog_model.sv */
// Purpose: Analog core stand-in that feeds sar_data to the sequencer.
// Assumes: The bench sets the analog level between conversions.
// Notes: Outside a conversion the lines carry the inverse level.
`timescale 1ns/1ps
module acs_analog_model (
  input wire logic converter_busy,
  input wire logic [9:0] level,
  output logic [9:0] sar_data
);
  // Data is valid only while converting, so a stale sample never looks right.
  assign sar_data = converter_busy ? level : ~level;
endmodule

/* File: sim/acs_top_sva.sv */
// Purpose: Port-level checks of the conversion sequencer.
// Assumes: Bound to acs_top; shadows follow accepted register writes.
// Notes: Abort latencies allow one registered stage of slack.
`timescale 1ns/1ps
module acs_top_sva (
  input wire mclk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq,
  input wire async_clk_en,
  input wire sample_en,
  input wire converter_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic hwt_r;
  logic ien_r;
  logic [1:0] csel_r;
  wire wr_ok = avs_write && !avs_waitrequest;
  // Shadows of the control bits that gate the outputs.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      hwt_r <= 1'b0;
      ien_r <= 1'b0;
      csel_r <= 2'h0;
    end
    else if (wr_ok && avs_address == 4'h1)
      hwt_r <= avs_writedata[6];
    else if (wr_ok && avs_address == 4'h0)
      ien_r <= avs_writedata[6];
    else if (wr_ok && avs_address == 4'h6)
      csel_r <= avs_writedata[1:0];
  end
  // ****************************************
  // Assertions
  // ****************************************
  chk_wait_one: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_sw_start: assert property (
    wr_ok && avs_address == 4'h0 && avs_writedata[4:0] != 5'h1f && !hwt_r |-> ##[1:3] converter_busy)
    else $error("software write did not start");
  chk_ch_off: assert property (
    wr_ok && avs_address == 4'h0 && avs_writedata[4:0] == 5'h1f |-> ##[1:2] !converter_busy)
    else $error("converter on with channel off");
  chk_mode_abort: assert property (
    wr_ok && avs_address inside {4'h1, 4'h4, 4'h5, 4'h6} |-> ##[1:2] !converter_busy)
    else $error("mode write did not abort");
  chk_sample_busy: assert property (sample_en |-> converter_busy)
    else $error("sampling while idle");
  chk_async_sel: assert property (async_clk_en |-> converter_busy && csel_r == 2'h3)
    else $error("async clock on without need");
  chk_irq_enable: assert property ($rose(irq) |-> ien_r)
    else $error("interrupt while disabled");
endmodule

/* File: sim/acs_top_test.sv */
// Purpose: Self-checking bench of the conversion sequencer.
// Assumes: Avalon master tasks; the analog model supplies sar_data.
// Notes: Reads queue their expected bytes; a monitor compares them.
`timescale 1ns/1ps
module acs_top_test;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic hw_trigger_in = 1'b0;
  logic stop_req = 1'b0;
  logic async_seen = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [9:0] level = 10'h155;
  wire [31:0] avs_readdata;
  wire [9:0] sar_data;
  wire avs_waitrequest, irq, async_clk_en, sample_en, converter_busy;
  logic [7:0] exp_q[$], msk_q[$];
  logic [7:0] cfgs[5] = '{8'h08, 8'h00, 8'h18, 8'h10, 8'h0b};
  int lims[5] = '{31, 28, 51, 48, 35};
  logic [12:0] abt[7] = '{13'h0200, 13'h0804, 13'h0a00, 13'h0c30, 13'h0083, 13'h00c3, 13'h003e};
  int n_errors = 0;
  int compares = 0;
  always #10 mclk = ~mclk;
  acs_top #(.ASYNC_START_CYC(4)) uut (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hw_trigger_in(hw_trigger_in), .stop_req(stop_req), .sar_data(sar_data),
    .irq(irq), .async_clk_en(async_clk_en), .sample_en(sample_en), .converter_busy(converter_busy));
  acs_analog_model ana (.converter_busy(converter_busy), .level(level), .sar_data(sar_data));
  always @(posedge mclk)
    if (async_clk_en)
      async_seen <= 1'b1;
  task automatic finish_test();
    $display("Compares %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic c, input string m);
    compares++;
    if (c !== 1'b1)
    begin
      n_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  // ****************************************
  // Bus master: holds the request until waitrequest is seen low
  // ****************************************
  task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20)
    begin
      check(1'b0, "bus timeout");
      finish_test();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 8'h00);
  endtask
  // Waits out one conversion and checks its length against the limit.
  task automatic run_conv(input int bound);
    int n;
    n = 0;
    while (converter_busy !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      n++;
    end
    check(n < 8, "conversion did not start");
    while (converter_busy === 1'b1 && n < 600)
    begin
      @(posedge mclk);
      n++;
    end
    check(n > 0 && n <= bound, "conversion time");
    if (n >= 600)
      finish_test();
    @(posedge mclk);
  endtask
  // The monitor takes the oldest note whenever a read is answered.
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected read");
      else
        check(((avs_readdata[7:0] ^ exp_q.pop_front()) & msk_q.pop_front()) === 8'h0
          && avs_readdata[31:8] === 24'h0, "read data");
    end
  initial
  begin
    int i;
    logic [9:0] old;
    i = $urandom(32'h4ce1);
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(4'h0, 8'h1f, 8'hff);
    rd(4'h7, 8'h00, 8'hff);
    for (i = 0; i < 5; i++)
    begin
      bus(1'b0, 4'h6, cfgs[i]);
      level <= 10'($urandom_range(1023, 0));
      bus(1'b0, 4'h0, 8'h41);
      run_conv(lims[i]);
      check(irq === 1'b1, "done interrupt");
      rd(4'h0, 8'h80, 8'h80);
      rd(4'h2, cfgs[i][3] ? {6'h0, level[9:8]} : 8'h00, 8'hff);
      rd(4'h3, cfgs[i][3] ? level[7:0] : level[9:2], 8'hff);
    end
    check(async_seen === 1'b1, "async clock never enabled");
    bus(1'b0, 4'h6, 8'h08);
    bus(1'b0, 4'h0, 8'h41);
    run_conv(31);
    old = level;
    rd(4'h2, {6'h0, old[9:8]}, 8'hff);
    level <= ~old;
    bus(1'b0, 4'h0, 8'h41);
    repeat (40) @(posedge mclk);
    check(converter_busy === 1'b1 && irq === 1'b0, "blocked transfer");
    rd(4'h3, old[7:0], 8'hff);
    run_conv(31);
    rd(4'h2, {6'h0, level[9:8]}, 8'hff);
    rd(4'h3, level[7:0], 8'hff);
    bus(1'b0, 4'h4, 8'h02);
    bus(1'b0, 4'h5, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'h1, i[1] ? 8'h30 : 8'h20);
      level <= i[0] ? 10'h300 : 10'h100;
      bus(1'b0, 4'h0, 8'h41);
      run_conv(31);
      check(irq === (i[1] == i[0]), "compare flag");
      rd(4'h2, (i == 3) ? 8'h01 : 8'h03, 8'hff);
      rd(4'h3, 8'h00, 8'hff);
    end
    bus(1'b0, 4'h6, 8'h18);
    for (i = 0; i < 7; i++)
    begin
      bus(1'b0, 4'h0, 8'h41);
      repeat (10) @(posedge mclk);
      bus(1'b0, abt[i][12:9], abt[i][8:1]);
      repeat (3) @(posedge mclk);
      check(converter_busy === abt[i][0], "abort");
    end
    rd(4'h2, 8'h01, 8'hff);
    bus(1'b0, 4'h6, 8'h08);
    bus(1'b0, 4'h1, 8'h40);
    bus(1'b0, 4'h0, 8'h21);
    repeat (5) @(posedge mclk);
    check(converter_busy === 1'b0, "write started in hardware mode");
    hw_trigger_in <= 1'b1;
    repeat (6) @(posedge mclk);
    check(converter_busy === 1'b1, "trigger edge");
    hw_trigger_in <= 1'b0;
    repeat (100) @(posedge mclk);
    check(converter_busy === 1'b1, "continuous run");
    stop_req <= 1'b1;
    repeat (5) @(posedge mclk);
    check(converter_busy === 1'b0, "stop abort");
    stop_req <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(4'h2, 8'h00, 8'hff);
    rd(4'h3, 8'h00, 8'hff);
    rd(4'h0, 8'h1f, 8'hff);
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
bind acs_top acs_top_sva chk (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .async_clk_en(async_clk_en), .sample_en(sample_en),
  .converter_busy(converter_busy));
